// ### logic/radio_service_status_regs.sv
// Service and status registers of the radio: calibration, temperature, low supply, flags
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "radio_service_status_regs.svh"
module radio_service_status_regs
   import radio_service_status_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire mode_t mode,
   input wire logic osc_running,
   input wire logic pll_locked,
   input wire logic rssi_sampling,
   input wire logic rx_settled,
   input wire logic pa_ramp_done,
   input wire logic [7:0] signal_strength_value,
   input wire logic [7:0] signal_strength_threshold,
   input wire logic timeout_event,
   input wire logic preamble_event,
   input wire logic sync_event,
   input wire logic packet_mode,
   input wire logic [6:0] buffer_count,
   input wire logic [6:0] buffer_level_threshold,
   input wire logic overrun_event,
   input wire logic packet_sent_event,
   input wire logic payload_last_byte,
   input wire logic crc_enable,
   input wire logic check_autoflush_disable,
   input wire logic crc_good_event,
   input wire logic supply_below,
   input wire logic [7:0] temp_sample,
   input wire logic temp_sample_valid,
   input wire logic calibration_done,
   output logic auto_calibration_enable,
   output logic calibration_start,
   output logic calibration_in_progress,
   output logic temperature_monitor_on,
   output logic low_supply_detector_enable,
   output logic [2:0] low_supply_threshold_trim,
   output logic buffer_flush
);
   // ******************************
   // Helpers
   // ******************************
   // Word index of a byte address
   function automatic logic [5:0] reg_index(input logic [7:0] a);
      return a[7:2];
   endfunction : reg_index

   // True when the index names a register of this group
   function automatic logic idx_mapped(input logic [5:0] i);
      return (i >= `IDX_IMAGE_CAL) && (i <= `IDX_FLAGS2);
   endfunction : idx_mapped

   // Magnitude of the difference of two temperature bytes
   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      return (a > b) ? 8'(a - b) : 8'(b - a);
   endfunction : abs_diff

   state_t s_reg;
   state_t s_next;
   logic wr_go;
   logic rd_go;
   logic wr_bit_set;
   logic [7:0] wv;
   logic wr_cal;
   logic wr_ls;
   logic wr_f1;
   logic wr_f2;
   logic buf_full;
   logic buf_empty;
   logic buf_level;
   logic mode_change;
   logic leave_rx;
   logic leave_tx;
   logic [7:0] thr_deg;
   logic [7:0] flags1;
   logic [7:0] flags2;
   logic [7:0] rd_val;
   logic payload_ok;
   logic trig_cal;
   logic auto_cal;

   // ******************************
   // Bus handshakes and decode
   // ******************************
   // Address and data are held apart until both are in
   assign awready = !s_reg.aw_held;
   assign wready = !s_reg.w_held;
   assign arready = !s_reg.rvalid;
   assign wr_go = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
   assign rd_go = arvalid && !s_reg.rvalid;
   assign wr_bit_set = wr_go && s_reg.w_strb0;
   assign wv = s_reg.w_data;
   assign wr_cal = wr_bit_set && (s_reg.aw_idx == `IDX_IMAGE_CAL);
   assign wr_ls = wr_bit_set && (s_reg.aw_idx == `IDX_LOW_SUPPLY);
   assign wr_f1 = wr_bit_set && (s_reg.aw_idx == `IDX_FLAGS1);
   assign wr_f2 = wr_bit_set && (s_reg.aw_idx == `IDX_FLAGS2);

   // Buffer state flags follow the count directly
   assign buf_full = (buffer_count == `BUF_FULL_COUNT);
   assign buf_empty = (buffer_count == 7'h00);
   assign buf_level = (buffer_count > buffer_level_threshold);

   // Mode transitions
   assign mode_change = (mode != s_reg.mode_prev);
   assign leave_rx = (s_reg.mode_prev == MODE_RX) && (mode != MODE_RX);
   assign leave_tx = (s_reg.mode_prev == MODE_TX) && (mode != MODE_TX);

   // Drift threshold in degrees: step times (code + 1)
   assign thr_deg = 8'((8'(s_reg.drift_thr) + 8'h01) * `DRIFT_STEP_DEG);

   // Payload is ready only when the check passes or is not gating
   assign payload_ok = payload_last_byte &&
      (!crc_enable || check_autoflush_disable || crc_good_event);

   // Calibration launch requests
   assign trig_cal = wr_cal && wv[`BIT_CAL_TRIG] && (mode == MODE_STANDBY);
   assign auto_cal = s_reg.auto_en && s_reg.drift && s_reg.mon_on;

   // Flag bytes as software sees them
   assign flags1 = {s_reg.f_mode_ready, s_reg.f_rx_ready, s_reg.f_tx_ready, s_reg.f_lock,
      s_reg.f_rssi, s_reg.f_timeout, s_reg.f_preamble, s_reg.f_sync};
   assign flags2 = {buf_full, buf_empty, buf_level, s_reg.f_overrun,
      s_reg.f_sent, s_reg.f_payload, s_reg.f_crc, s_reg.f_low_supply};

   // Read multiplexer; trigger and unused bits read as zero
   always_comb begin
      unique case (reg_index(araddr))
         `IDX_IMAGE_CAL: rd_val = {s_reg.auto_en, 1'b0,
            (s_reg.cal_state == CAL_RUN), 1'b0, s_reg.drift, s_reg.drift_thr, s_reg.mon_off};
         `IDX_TEMP: rd_val = s_reg.temp;
         `IDX_LOW_SUPPLY: rd_val = {4'h0, s_reg.ls_on, s_reg.ls_trim};
         `IDX_FLAGS1: rd_val = flags1;
         `IDX_FLAGS2: rd_val = flags2;
         default: rd_val = 8'h00;
      endcase
   end

   // ******************************
   // Next state
   // ******************************
   // All state advances here; set wins over clear for every flag except mode ready, rx ready, tx ready, lock and sent, where the mode condition wins
   always_comb begin
      s_next = s_reg;
      s_next.cal_start = 1'b0;
      s_next.flush = 1'b0;
      s_next.mode_prev = mode;
      // Write channel capture
      if (awvalid && !s_reg.aw_held) begin
         s_next.aw_held = 1'b1;
         s_next.aw_idx = reg_index(awaddr);
      end
      if (wvalid && !s_reg.w_held) begin
         s_next.w_held = 1'b1;
         s_next.w_data = wdata[7:0];
         s_next.w_strb0 = wstrb[0];
      end
      if (wr_go) begin
         s_next.aw_held = 1'b0;
         s_next.w_held = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = idx_mapped(s_reg.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      // Read channel
      if (rd_go) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_val;
         s_next.rresp = idx_mapped(reg_index(araddr)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      // Writable control fields
      if (wr_cal) begin
         s_next.auto_en = wv[`BIT_AUTO_CAL];
         s_next.drift_thr = wv[2:1];
         s_next.mon_off = wv[`BIT_MON_OFF];
      end
      if (wr_ls) begin
         s_next.ls_on = wv[`BIT_LS_ON];
         s_next.ls_trim = wv[2:0];
      end
      // Monitoring runs outside sleep and standby unless disabled
      s_next.mon_on = !s_reg.mon_off && (mode != MODE_SLEEP) && (mode != MODE_STANDBY);
      if (s_reg.mon_on && temp_sample_valid) begin
         s_next.temp = temp_sample;
      end
      s_next.drift = abs_diff(s_reg.temp, s_reg.former_temp) > thr_deg;
      // Calibration sequencer
      unique case (s_reg.cal_state)
         CAL_IDLE: begin
            if (trig_cal || auto_cal) begin
               s_next.cal_state = CAL_RUN;
               s_next.cal_start = 1'b1;
            end
         end
         CAL_RUN: begin
            if (calibration_done) begin
               s_next.cal_state = CAL_IDLE;
               s_next.former_temp = s_reg.temp;
               s_next.drift = 1'b0;
            end
         end
      endcase
      // Mode readiness
      if (mode_change) begin
         s_next.f_mode_ready = 1'b0;
      end else if ((mode == MODE_SLEEP) || (mode == MODE_STANDBY && osc_running) ||
            (mode == MODE_SYNTH && pll_locked) || (mode == MODE_RX && rssi_sampling) ||
            (mode == MODE_TX && pa_ramp_done)) begin
         s_next.f_mode_ready = 1'b1;
      end
      s_next.f_rx_ready = (mode == MODE_RX) && (s_reg.f_rx_ready || rx_settled);
      s_next.f_tx_ready = (mode == MODE_TX) && (s_reg.f_tx_ready || pa_ramp_done);
      s_next.f_lock = pll_locked && (mode == MODE_SYNTH || mode == MODE_RX ||
         mode == MODE_TX);
      // Receive event flags
      if (leave_rx || (wr_f1 && wv[`BIT_RSSI])) begin
         s_next.f_rssi = 1'b0;
      end
      if (mode == MODE_RX && rssi_sampling &&
            signal_strength_value > signal_strength_threshold) begin
         s_next.f_rssi = 1'b1;
      end
      if (leave_rx || buf_empty) begin
         s_next.f_timeout = 1'b0;
      end
      if (timeout_event) begin
         s_next.f_timeout = 1'b1;
      end
      if (wr_f1 && wv[`BIT_PREAMBLE]) begin
         s_next.f_preamble = 1'b0;
      end
      if (preamble_event) begin
         s_next.f_preamble = 1'b1;
      end
      if (leave_rx || buf_empty || (wr_f1 && !packet_mode && wv[`BIT_SYNC])) begin
         s_next.f_sync = 1'b0;
      end
      if (sync_event) begin
         s_next.f_sync = 1'b1;
      end
      // Buffer, packet and low supply flags
      if (wr_f2 && wv[`BIT_OVERRUN]) begin
         s_next.f_overrun = 1'b0;
         s_next.flush = 1'b1;
      end
      if (overrun_event && mode != MODE_SLEEP) begin
         s_next.f_overrun = 1'b1;
      end
      s_next.f_sent = (mode == MODE_TX) && (s_reg.f_sent || packet_sent_event);
      if (buf_empty) begin
         s_next.f_payload = 1'b0;
         s_next.f_crc = 1'b0;
      end
      if (mode == MODE_RX && payload_ok) begin
         s_next.f_payload = 1'b1;
      end
      if (mode == MODE_RX && crc_good_event) begin
         s_next.f_crc = 1'b1;
      end
      if (wr_f2 && wv[`BIT_LOW_SUPPLY]) begin
         s_next.f_low_supply = 1'b0;
      end
      if (s_reg.ls_on && supply_below) begin
         s_next.f_low_supply = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.drift_thr <= `RST_DRIFT_THR;
         s_reg.ls_trim <= `RST_LS_TRIM;
      end else begin
         s_reg <= s_next;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign rvalid = s_reg.rvalid;
   assign rresp = s_reg.rresp;
   assign rdata = {24'h000000, s_reg.rdata};
   assign auto_calibration_enable = s_reg.auto_en;
   assign calibration_start = s_reg.cal_start;
   assign calibration_in_progress = (s_reg.cal_state == CAL_RUN);
   assign temperature_monitor_on = s_reg.mon_on;
   assign low_supply_detector_enable = s_reg.ls_on;
   assign low_supply_threshold_trim = s_reg.ls_trim;
   assign buffer_flush = s_reg.flush;

   // ******************************
   // Checks
   // ******************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence wr_both_in;
      s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
   endsequence
   sequence wr_answered;
      ##1 bvalid ##1 (!bvalid || !$past(bready));
   endsequence

   write_answer_a: assert property (wr_both_in |-> wr_answered)
      else $error("write not answered one cycle after capture");
   trig_start_a: assert property (trig_cal && !calibration_in_progress |=>
      calibration_in_progress && calibration_start)
      else $error("standby trigger did not start calibration");
   cal_end_a: assert property (calibration_in_progress && calibration_done |=>
      !calibration_in_progress)
      else $error("calibration did not end on done");
   no_auto_a: assert property (!calibration_in_progress && !trig_cal && !s_reg.auto_en
      |=> !calibration_in_progress)
      else $error("calibration started without trigger or auto enable");
   lock_track_a: assert property (pll_locked && mode == MODE_RX |=> s_reg.f_lock)
      else $error("lock flag missed");
   rx_leave_a: assert property (leave_rx && !timeout_event |=>
      !s_reg.f_rx_ready && !s_reg.f_timeout)
      else $error("receive flags kept after leaving receive");
   flush_w1c_a: assert property (wr_f2 && wv[`BIT_OVERRUN] |=> buffer_flush
      ##1 !buffer_flush)
      else $error("overrun clear did not flush once");
   low_hold_a: assert property (s_reg.f_low_supply && !(wr_f2 && wv[`BIT_LOW_SUPPLY])
      |=> s_reg.f_low_supply)
      else $error("low supply flag cleared without write");
   preamble_set_a: assert property (preamble_event |=> s_reg.f_preamble)
      else $error("preamble event lost");
   full_read_a: assert property (rd_go && reg_index(araddr) == `IDX_FLAGS2
      |=> rdata[7] == $past(buf_full) && rdata[6] == $past(buf_empty))
      else $error("buffer fill flags read wrong");
   ctrl_kept_a: assert property (!wr_ls |=> $stable(low_supply_threshold_trim))
      else $error("trim changed without a write");
endmodule : radio_service_status_regs

// ### shared/radio_service_status_regs.svh
// Register indices, field positions, reset values and counts of the service and status group
`ifndef RADIO_SERVICE_STATUS_REGS_SVH
`define RADIO_SERVICE_STATUS_REGS_SVH
// ******************************
// Register indices (byte address = 4 * index)
// ******************************
`define IDX_IMAGE_CAL 6'h3B
`define IDX_TEMP 6'h3C
`define IDX_LOW_SUPPLY 6'h3D
`define IDX_FLAGS1 6'h3E
`define IDX_FLAGS2 6'h3F
// ******************************
// Field positions
// ******************************
`define BIT_AUTO_CAL 7
`define BIT_CAL_TRIG 6
`define BIT_CAL_RUN 5
`define BIT_DRIFT 3
`define BIT_MON_OFF 0
`define BIT_LS_ON 3
`define BIT_RSSI 3
`define BIT_PREAMBLE 1
`define BIT_SYNC 0
`define BIT_OVERRUN 4
`define BIT_LOW_SUPPLY 0
// ******************************
// Reset values and counts
// ******************************
`define RST_DRIFT_THR 2'h1
`define RST_LS_TRIM 3'h2
`define BUF_FULL_COUNT 7'h42
`define DRIFT_STEP_DEG 8'h05
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### shared/radio_service_status_pkg.sv
// Types of the service and status register group
package radio_service_status_pkg;
   typedef enum logic [2:0] {
      MODE_SLEEP = 3'h0,
      MODE_STANDBY = 3'h1,
      MODE_SYNTH = 3'h2,
      MODE_TX = 3'h3,
      MODE_RX = 3'h4
   } mode_t;
   typedef enum logic [0:0] {
      CAL_IDLE = 1'h0,
      CAL_RUN = 1'h1
   } cal_state_t;
   typedef struct packed {
      logic aw_held;
      logic [5:0] aw_idx;
      logic w_held;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      cal_state_t cal_state;
      logic cal_start;
      logic auto_en;
      logic [1:0] drift_thr;
      logic mon_off;
      logic mon_on;
      logic ls_on;
      logic [2:0] ls_trim;
      logic [7:0] temp;
      logic [7:0] former_temp;
      logic drift;
      mode_t mode_prev;
      logic f_mode_ready;
      logic f_rx_ready;
      logic f_tx_ready;
      logic f_lock;
      logic f_rssi;
      logic f_timeout;
      logic f_preamble;
      logic f_sync;
      logic f_overrun;
      logic f_sent;
      logic f_payload;
      logic f_crc;
      logic f_low_supply;
      logic flush;
   } state_t;
endpackage : radio_service_status_pkg

// ### tb/radio_service_status_regs_tb.sv
// Self-checking bench of the service and status register group
`timescale 1ns/1ps
`include "radio_service_status_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module radio_service_status_regs_tb
   import radio_service_status_pkg::*;
;
   // *****
   // Signals
   // *****
   localparam logic [7:0] a_cal = {`IDX_IMAGE_CAL, 2'b00};
   localparam logic [7:0] a_temp = {`IDX_TEMP, 2'b00};
   localparam logic [7:0] a_ls = {`IDX_LOW_SUPPLY, 2'b00};
   localparam logic [7:0] a_f1 = {`IDX_FLAGS1, 2'b00};
   localparam logic [7:0] a_f2 = {`IDX_FLAGS2, 2'b00};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   mode_t mode = MODE_SLEEP;
   logic osc = 1'b0, pll = 1'b0, rssi_s = 1'b0, rx_set = 1'b0, pa_done = 1'b0, below = 1'b0;
   logic [7:0] sval = 8'h00, sthr = 8'h40, tsamp = 8'h00;
   logic [6:0] count = 7'h00, lthr = 7'h0A;
   logic [8:0] ev = 9'h000;
   logic pmode = 1'b1, crc_en = 1'b0, acd = 1'b0;
   logic cal_on, start, in_prog, mon_on, ls_on, flush;
   logic [2:0] trim;
   logic [7:0] starts = 8'h00, flushes = 8'h00, k;
   int num_errors = 0, num_checks = 0;

   // Clock at 200 MHz
   always #2.5 clk = ~clk;

   // Count one-cycle pulses of the design
   always @(posedge clk) begin
      if (start) starts <= starts + 8'h01;
      if (flush) flushes <= flushes + 8'h01;
   end

   radio_service_status_regs uut (
      .clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mode(mode), .osc_running(osc), .pll_locked(pll), .rssi_sampling(rssi_s),
      .rx_settled(rx_set), .pa_ramp_done(pa_done), .signal_strength_value(sval),
      .signal_strength_threshold(sthr), .timeout_event(ev[0]), .preamble_event(ev[1]),
      .sync_event(ev[2]), .packet_mode(pmode), .buffer_count(count),
      .buffer_level_threshold(lthr), .overrun_event(ev[3]), .packet_sent_event(ev[4]),
      .payload_last_byte(ev[5]), .crc_enable(crc_en), .check_autoflush_disable(acd),
      .crc_good_event(ev[6]), .supply_below(below), .temp_sample(tsamp),
      .temp_sample_valid(ev[8]), .calibration_done(ev[7]), .auto_calibration_enable(cal_on),
      .calibration_start(start), .calibration_in_progress(in_prog),
      .temperature_monitor_on(mon_on), .low_supply_detector_enable(ls_on),
      .low_supply_threshold_trim(trim), .buffer_flush(flush)
   );

   // *****
   // Tasks
   // *****
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // Settle n edges, then look between edges
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : idle

   // AXI4-Lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] er = `RESP_OKAY);
      logic pa, pw, pb, ta, tw, tb;
      logic [1:0] rsp;
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      n = 0;
      while (pb) begin
         @(negedge clk);
         ta = pa && awready;
         tw = pw && wready;
         tb = !pa && !pw && bvalid;
         rsp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
         pb = !tb;
         n++;
         if (n > 50) begin num_errors++; finish_test(); end
      end
      `CHK(rsp, er)
   endtask : wr

   // AXI4-Lite read compared under a mask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF,
                       input logic [1:0] er = `RESP_OKAY);
      logic pa, ta, tr;
      logic [31:0] d;
      logic [1:0] rsp;
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      tr = 1'b0;
      n = 0;
      while (!tr) begin
         @(negedge clk);
         ta = pa && arready;
         tr = !pa && rvalid;
         d = rdata;
         rsp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         pa = pa && !ta;
         n++;
         if (n > 50) begin num_errors++; finish_test(); end
      end
      `CHK(d & {24'hFFFFFF, m}, {24'h0, e})
      `CHK(rsp, er)
   endtask : rchk

   // One-cycle event pulse on a bit of ev
   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
   endtask : pulse

   task automatic samp(input logic [7:0] d);
      @(posedge clk);
      tsamp <= d;
      pulse(8);
   endtask : samp

   task automatic wait_prog;
      int n;
      n = 0;
      while (in_prog !== 1'b1 && n < 10) begin idle(0); @(posedge clk); n++; end
      idle(0);
      `CHK(in_prog, 1'b1)
   endtask : wait_prog

   task automatic lvl(input logic [6:0] c, input logic [7:0] e);
      @(posedge clk);
      count <= c;
      idle(1);
      rchk(a_f2, e);
   endtask : lvl

   // *****
   // Scenarios
   // *****
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      idle(1);
      `CHK(trim, 3'h2)
      rchk(a_cal, 8'h02);
      rchk(a_ls, 8'h02);
      rchk(a_f2, 8'h40);
      rchk(8'h00, 8'h00, 8'hFF, `RESP_SLVERR);
      wr(8'h00, 8'hFF, 4'hF, `RESP_SLVERR);
      // Temperature capture, drift and thresholds
      @(posedge clk);
      mode <= MODE_STANDBY;
      osc <= 1'b1;
      samp(8'h33);
      idle(1);
      `CHK(mon_on, 1'b0)
      rchk(a_temp, 8'h00);
      @(posedge clk);
      mode <= MODE_RX;
      samp(8'h0A);
      idle(1);
      `CHK(mon_on, 1'b1)
      rchk(a_temp, 8'h0A);
      rchk(a_cal, 8'h02);
      samp(8'h0B);
      idle(2);
      rchk(a_cal, 8'h0A);
      wr(a_cal, 8'h06);
      rchk(a_cal, 8'h06);
      wr(a_cal, 8'h04);
      rchk(a_cal, 8'h04);
      wr(a_cal, 8'h01);
      samp(8'h44);
      idle(2);
      `CHK(mon_on, 1'b0)
      rchk(a_temp, 8'h0B);
      rchk(a_cal, 8'h09);
      // Automatic and triggered calibration
      `CHK(in_prog, 1'b0)
      wr(a_cal, 8'h80);
      wait_prog();
      `CHK(cal_on, 1'b1)
      wr(a_cal, 8'h81);
      pulse(7);
      idle(2);
      `CHK(in_prog, 1'b0)
      rchk(a_cal, 8'h81);
      @(posedge clk);
      mode <= MODE_SYNTH;
      k = starts;
      wr(a_cal, 8'h40);
      idle(3);
      `CHK(in_prog, 1'b0)
      `CHK(starts, k)
      @(posedge clk);
      mode <= MODE_STANDBY;
      wr(a_cal, 8'h40);
      wait_prog();
      `CHK(starts, k + 8'h01)
      rchk(a_cal, 8'h20, 8'hBF);
      pulse(7);
      idle(2);
      `CHK(in_prog, 1'b0)
      // Low supply detector
      wr(a_ls, 8'h0F);
      idle(1);
      `CHK(ls_on, 1'b1)
      `CHK(trim, 3'h7)
      rchk(a_ls, 8'h0F);
      @(posedge clk);
      below <= 1'b1;
      idle(2);
      @(posedge clk);
      below <= 1'b0;
      rchk(a_f2, 8'h41);
      wr(a_f2, 8'h00);
      wr(a_f2, 8'h01, 4'h0);
      rchk(a_f2, 8'h41);
      wr(a_f2, 8'h01);
      rchk(a_f2, 8'h40);
      wr(a_ls, 8'h05);
      @(posedge clk);
      below <= 1'b1;
      idle(2);
      `CHK(ls_on, 1'b0)
      rchk(a_f2, 8'h40);
      // First flag register through receive, transmit and synth
      @(posedge clk);
      below <= 1'b0;
      mode <= MODE_RX;
      pll <= 1'b1;
      rssi_s <= 1'b1;
      rx_set <= 1'b1;
      sval <= 8'h50;
      count <= 7'h05;
      pulse(0);
      pulse(1);
      pulse(2);
      idle(2);
      rchk(a_f1, 8'hDF);
      @(posedge clk);
      sval <= 8'h40;
      wr(a_f1, 8'h00);
      rchk(a_f1, 8'hDF);
      wr(a_f1, 8'hFF);
      rchk(a_f1, 8'hD5);
      // Continuous mode lets software clear the sync flag
      @(posedge clk);
      pmode <= 1'b0;
      wr(a_f1, 8'h01);
      rchk(a_f1, 8'hD4);
      lvl(7'h00, 8'h40);
      rchk(a_f1, 8'hD0);
      @(posedge clk);
      pll <= 1'b0;
      idle(2);
      rchk(a_f1, 8'h40, 8'h7F);
      @(posedge clk);
      pll <= 1'b1;
      sval <= 8'h41;
      idle(2);
      rchk(a_f1, 8'hD8);
      @(posedge clk);
      mode <= MODE_TX;
      pa_done <= 1'b1;
      idle(3);
      rchk(a_f1, 8'hB0);
      @(posedge clk);
      mode <= MODE_SYNTH;
      pll <= 1'b0;
      idle(3);
      rchk(a_f1, 8'h00);
      @(posedge clk);
      pll <= 1'b1;
      idle(3);
      rchk(a_f1, 8'h90);
      @(posedge clk);
      mode <= MODE_STANDBY;
      idle(3);
      rchk(a_f1, 8'h80);
      // Second flag register: levels, overrun, payload, sent
      @(posedge clk);
      mode <= MODE_RX;
      lvl(7'h0A, 8'h00);
      lvl(7'h0B, 8'h20);
      lvl(7'h41, 8'h20);
      lvl(`BUF_FULL_COUNT, 8'hA0);
      lvl(7'h05, 8'h00);
      // Check gating: last byte alone is not enough, unless gating is off
      @(posedge clk);
      crc_en <= 1'b1;
      pulse(5);
      idle(2);
      rchk(a_f2, 8'h00);
      @(posedge clk);
      acd <= 1'b1;
      pulse(5);
      idle(2);
      rchk(a_f2, 8'h04);
      @(posedge clk);
      crc_en <= 1'b0;
      acd <= 1'b0;
      pulse(3);
      pulse(5);
      pulse(6);
      idle(2);
      rchk(a_f2, 8'h16);
      k = flushes;
      wr(a_f2, 8'h10);
      idle(2);
      `CHK(flushes, k + 8'h01)
      rchk(a_f2, 8'h06);
      wr(a_f2, 8'h0F);
      rchk(a_f2, 8'h06);
      lvl(7'h00, 8'h40);
      @(posedge clk);
      mode <= MODE_SLEEP;
      pulse(3);
      idle(2);
      rchk(a_f2, 8'h40);
      @(posedge clk);
      mode <= MODE_TX;
      pulse(4);
      idle(2);
      rchk(a_f2, 8'h48);
      @(posedge clk);
      mode <= MODE_STANDBY;
      idle(2);
      rchk(a_f2, 8'h40);
      finish_test();
   end
endmodule : radio_service_status_regs_tb
